// ==== hw/csi_core.sv ====
// return stack, interrupt context shadowing and indirect pointers behind an apb slave
//
// How it works
// [R1] return stack of sixteen 15-bit entries
// [R2] push when full or pop when empty flags
// [R3] optional stack-error reset of the core
// [R4] context copied to shadow and back automatically
// [R5] two 16-bit pointers over one address space
// [R6] program-memory indirect access adds one cycle
// [R7] linear window maps banked general-purpose memory
// [R8] dedicated pointer instructions among the command set
// [R9] interrupt entry flushes, clears enable, pushes, vectors
// [R10] return pops, restores context, sets enable again
// [R11] stack flags sticky, survive the stack reset
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
`include "csi_defines.svh"
module csi_core
	import csi_pkg::*;
#(
	parameter int DEPTH = `CSI_STACK_DEPTH
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             stack_reset_pulse,
	output logic             prefetch_flush
);
	localparam int SW = `CSI_STACK_WIDTH;
	localparam int PW = `CSI_PTR_WIDTH;

	logic [SW-1:0] stack_mem [DEPTH];
	logic [4:0]    sp_reg;
	logic [SW-1:0] pc_reg;
	logic [PW-1:0] ptr_reg [2];
	logic [PW-1:0] ctx_reg;
	logic [PW-1:0] sh_ctx_reg;
	logic [PW-1:0] sh_ptr_reg [2];
	logic          ovf_reg;
	logic          unf_reg;
	logic          rsten_reg;
	logic          gint_en_reg;
	logic [2:0]    istat_reg;
	logic [2:0]    imask_reg;
	logic [1:0]    ind_region_reg;
	logic [11:0]   ind_phys_reg;
	logic          ind_extra_reg;

	// apb decode
	wire [9:0] idx        = paddr[11:2];
	wire       acc_fire   = psel & penable & pready;
	wire       wr_fire    = acc_fire & pwrite;
	wire       setup      = psel & ~penable;
	wire       hit_cause  = idx == `CSI_IDX_CAUSE;
	wire       hit_ctrl   = idx == `CSI_IDX_CTRL;
	wire       hit_cmd    = idx == `CSI_IDX_CMD;
	wire       hit_pc     = idx == `CSI_IDX_PC;
	wire       hit_tos    = idx == `CSI_IDX_TOS;
	wire       hit_ptr0   = idx == `CSI_IDX_PTR0;
	wire       hit_ptr1   = idx == `CSI_IDX_PTR1;
	wire       hit_ctx    = idx == `CSI_IDX_CTX;
	wire       hit_shadow = idx == `CSI_IDX_SHADOW;
	wire       hit_ind    = idx == `CSI_IDX_IND;
	wire       hit_istat  = idx == `CSI_IDX_ISTAT;
	wire       hit_imask  = idx == `CSI_IDX_IMASK;
	wire       mapped     = hit_cause | hit_ctrl | hit_cmd | hit_pc | hit_tos | hit_ptr0
	                      | hit_ptr1 | hit_ctx | hit_shadow | hit_ind | hit_istat | hit_imask;

	// command fields
	wire [2:0]      op_bits = pwdata[`CSI_CMD_OP_HI:`CSI_CMD_OP_LO];
	wire csi_op_type op     = csi_op_type'(op_bits);
	wire            sel     = pwdata[`CSI_CMD_SEL];
	wire [PW-1:0]   imm     = {{(PW-6){pwdata[5]}}, pwdata[5:0]};
	wire            cmd_wr  = wr_fire & hit_cmd;
	wire            do_push = cmd_wr & (op == CSI_OP_PUSH);
	wire            do_pop  = cmd_wr & (op == CSI_OP_POP);
	wire            do_irq  = cmd_wr & (op == CSI_OP_IRQ) & gint_en_reg;
	wire            do_reti = cmd_wr & (op == CSI_OP_RETI);
	wire            do_ind  = cmd_wr & (op == CSI_OP_IND);
	wire            do_add  = cmd_wr & (op == CSI_OP_ADDPTR);

	// stack events; a push at full depth is dropped, a pop when empty returns zero
	wire       full      = sp_reg == 5'(DEPTH);
	wire       empty     = sp_reg == 5'h00;
	wire       any_push  = do_push | do_irq;
	wire       any_pop   = do_pop | do_reti;
	wire       ev_ovf    = any_push & full;                                   // [R2]
	wire       ev_unf    = any_pop & empty;                                   // [R2]
	wire       stk_rst   = (ev_ovf | ev_unf) & rsten_reg;                     // [R3]
	wire [SW-1:0] tos    = empty ? '0 : stack_mem[4'(sp_reg - 5'h01)];
	wire [SW-1:0] push_val = do_irq ? pc_reg : pwdata[SW-1:0];

	// one address space: file registers, linear window, program memory
	function automatic logic [13:0] csi_map(input logic [PW-1:0] p);
		logic [PW-1:0] off;
		logic [PW-1:0] bank;
		logic [PW-1:0] rem;
		off  = p - `CSI_LIN_BASE;
		bank = off / `CSI_BANK_BYTES;
		rem  = off % `CSI_BANK_BYTES;
		if (p[`CSI_PROG_BIT])
			csi_map = {CSI_REG_PROG, p[11:0]};
		else if (p >= `CSI_LIN_BASE && off < `CSI_LIN_SIZE)
			csi_map = {CSI_REG_LIN, bank[4:0], 7'h00} + {2'h0, `CSI_BANK_GPR}
			        + {7'h00, rem[6:0]};                                      // [R7]
		else
			csi_map = {CSI_REG_FILE, p[11:0]};
	endfunction : csi_map

	wire [PW-1:0] ptr_sel    = ptr_reg[sel];
	wire [13:0]   map_sel    = csi_map(ptr_sel);                              // [R5]
	// program memory needs a fetch, so the command waits one more cycle
	wire          need_extra = setup & pwrite & hit_cmd & (op == CSI_OP_IND)
	                         & ptr_sel[`CSI_PROG_BIT];                        // [R6]
	wire          pready_next = psel & ~pready & (penable | ~need_extra);
	wire          pslverr_next = pready_next & ~mapped;

	wire [31:0] rd_mux =
		hit_cause  ? {24'h0, ovf_reg, unf_reg, 6'h00} :
		hit_ctrl   ? {30'h0, gint_en_reg, rsten_reg} :
		hit_pc     ? {17'h0, pc_reg} :
		hit_tos    ? {11'h0, sp_reg, 1'b0, tos} :
		hit_ptr0   ? {16'h0, ptr_reg[0]} :
		hit_ptr1   ? {16'h0, ptr_reg[1]} :
		hit_ctx    ? {16'h0, ctx_reg} :
		hit_shadow ? {16'h0, sh_ctx_reg} :
		hit_ind    ? {7'h0, ind_extra_reg, 6'h0, ind_region_reg, 4'h0, ind_phys_reg} :
		hit_istat  ? {29'h0, istat_reg} :
		hit_imask  ? {29'h0, imask_reg} : 32'h0;

	// events set, write-one clears, a coincident set wins
	wire [2:0] ev_vec    = {stk_rst, ev_unf, ev_ovf};
	wire [2:0] istat_clr = (wr_fire & hit_istat) ? pwdata[2:0] : 3'h0;
	// cause flags clear only by writing zero, set wins; the stack reset never touches them
	wire       cause_wr  = wr_fire & hit_cause;
	wire       ovf_next  = ev_ovf | (ovf_reg & ~(cause_wr & ~pwdata[`CSI_CAUSE_OVF])); // [R11]
	wire       unf_next  = ev_unf | (unf_reg & ~(cause_wr & ~pwdata[`CSI_CAUSE_UNF])); // [R11]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= pready_next;
			pslverr <= pslverr_next;
			prdata  <= (setup & ~pwrite) ? rd_mux : prdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_reg   <= 1'b0;
			unf_reg   <= 1'b0;
			istat_reg <= 3'h0;
			imask_reg <= 3'h0;
			irq       <= 1'b0;
			rsten_reg <= 1'b0;
		end else begin
			ovf_reg   <= ovf_next;                                            // [R2]
			unf_reg   <= unf_next;                                            // [R2]
			istat_reg <= (istat_reg & ~istat_clr) | ev_vec;
			imask_reg <= (wr_fire & hit_imask) ? pwdata[2:0] : imask_reg;
			irq       <= |(((istat_reg & ~istat_clr) | ev_vec) & imask_reg);
			rsten_reg <= (wr_fire & hit_ctrl) ? pwdata[`CSI_CTRL_RSTEN] : rsten_reg;
		end
	end

	// stack pointer, program counter and enable; stack reset clears them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_reg            <= 5'h00;
			pc_reg            <= '0;
			gint_en_reg       <= 1'b0;
			stack_reset_pulse <= 1'b0;
			prefetch_flush    <= 1'b0;
		end else begin
			stack_reset_pulse <= stk_rst;                                     // [R3]
			prefetch_flush    <= do_irq;                                      // [R9]
			if (stk_rst) begin
				sp_reg  <= 5'h00;                                             // [R3]
				pc_reg  <= '0;
				gint_en_reg <= 1'b0;
			end else begin
				if (any_push & ~full)
					sp_reg <= sp_reg + 5'h01;                                 // [R1]
				else if (any_pop & ~empty)
					sp_reg <= sp_reg - 5'h01;
				if (do_irq)
					pc_reg <= `CSI_VECTOR;                                    // [R9]
				else if (do_reti)
					pc_reg <= tos;                                            // [R10]
				else if (wr_fire & hit_pc)
					pc_reg <= pwdata[SW-1:0];
				if (do_irq)
					gint_en_reg <= 1'b0;                                      // [R9]
				else if (do_reti)
					gint_en_reg <= 1'b1;                                      // [R10]
				else if (wr_fire & hit_ctrl)
					gint_en_reg <= pwdata[`CSI_CTRL_GINT];
			end
		end
	end

	// stack storage has no reset; only entries below the pointer are ever read
	always_ff @(posedge pclk) begin
		if (any_push & ~full & ~stk_rst)
			stack_mem[4'(sp_reg)] <= push_val;                                // [R1]
	end

	// context and pointers, with shadow copies around interrupts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctx_reg    <= '0;
			sh_ctx_reg <= '0;
		end else begin
			if (do_irq)
				sh_ctx_reg <= ctx_reg;                                        // [R4]
			if (do_reti)
				ctx_reg <= sh_ctx_reg;                                        // [R4]
			else if (wr_fire & hit_ctx)
				ctx_reg <= pwdata[PW-1:0];
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_ptr
		wire wr_ptr = wr_fire & (g == 0 ? hit_ptr0 : hit_ptr1);
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				ptr_reg[g]    <= '0;
				sh_ptr_reg[g] <= '0;
			end else begin
				if (do_irq)
					sh_ptr_reg[g] <= ptr_reg[g];                              // [R4]
				if (do_reti)
					ptr_reg[g] <= sh_ptr_reg[g];                              // [R4]
				else if (do_add & (sel == 1'(g)))
					ptr_reg[g] <= ptr_reg[g] + imm;                           // [R8]
				else if (wr_ptr)
					ptr_reg[g] <= pwdata[PW-1:0];                             // [R5]
			end
		end
	end

	// result of the latest indirect access, for software to inspect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_region_reg <= 2'h0;
			ind_phys_reg   <= 12'h000;
			ind_extra_reg  <= 1'b0;
		end else if (do_ind) begin
			ind_region_reg <= map_sel[13:12];                                 // [R5]
			ind_phys_reg   <= map_sel[11:0];
			ind_extra_reg  <= ptr_sel[`CSI_PROG_BIT];                         // [R6]
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	depth_bound_a: assert property (sp_reg <= 5'(DEPTH))                     // [R1]
		else $error("stack pointer beyond depth");
	ovf_flag_a: assert property (any_push && full |=> ovf_reg && sp_reg == 5'(DEPTH)
		|| stack_reset_pulse) else $error("overflow not flagged");            // [R2]
	unf_flag_a: assert property (any_pop && empty |=> unf_reg && istat_reg[`CSI_EV_UNF])
		else $error("underflow not flagged");                                 // [R2]
	stk_reset_a: assert property (stk_rst |=> stack_reset_pulse && sp_reg == 5'h00
		&& pc_reg == '0 ##1 !stack_reset_pulse) else $error("stack reset wrong"); // [R3]
	ctx_restore_a: assert property (do_reti |=> ctx_reg == $past(sh_ctx_reg)) // [R4]
		else $error("context not restored");
	extra_cycle_a: assert property (need_extra |=> !pready ##1 pready)
		else $error("no extra cycle for program memory");                    // [R6]
	short_cycle_a: assert property (setup && !need_extra |=> pready)
		else $error("plain access not answered at once");
	linear_map_a: assert property (do_ind && !ptr_sel[`CSI_PROG_BIT]
		&& ptr_sel >= `CSI_LIN_BASE && ptr_sel < `CSI_LIN_BASE + `CSI_LIN_SIZE
		|=> ind_region_reg == CSI_REG_LIN) else $error("linear window missed"); // [R7]
	ptr_add_a: assert property (do_add && !do_reti |=>
		ptr_reg[$past(sel)] == $past(ptr_sel) + $past(imm))
		else $error("pointer add wrong");                                     // [R8]
	irq_entry_a: assert property (do_irq && !stk_rst |=> pc_reg == `CSI_VECTOR
		&& !gint_en_reg && prefetch_flush) else $error("interrupt entry wrong"); // [R9]
	reti_enable_a: assert property (do_reti && !stk_rst |=> gint_en_reg) // [R10]
		else $error("enable not set on return");
	flag_keep_a: assert property (ovf_reg && !(cause_wr && !pwdata[`CSI_CAUSE_OVF])
		|=> ovf_reg) else $error("overflow flag lost");                       // [R11]

	irq_ret_c: cover property (do_irq ##[1:20] do_reti);
	ovf_rst_c: cover property (ev_ovf && rsten_reg);
	prog_ind_c: cover property (need_extra ##2 do_ind);
	irq_out_c: cover property (irq);
endmodule : csi_core

// ==== shared/csi_defines.svh ====
// register indexes, field positions, sizes, addresses and constants of the stack core
`ifndef CSI_DEFINES_SVH
`define CSI_DEFINES_SVH
`define CSI_IDX_CAUSE   10'h096
`define CSI_IDX_CTRL    10'h100
`define CSI_IDX_CMD     10'h101
`define CSI_IDX_PC      10'h102
`define CSI_IDX_TOS     10'h103
`define CSI_IDX_PTR0    10'h104
`define CSI_IDX_PTR1    10'h105
`define CSI_IDX_CTX     10'h106
`define CSI_IDX_SHADOW  10'h107
`define CSI_IDX_IND     10'h108
`define CSI_IDX_ISTAT   10'h109
`define CSI_IDX_IMASK   10'h10A
`define CSI_CAUSE_OVF   7
`define CSI_CAUSE_UNF   6
`define CSI_CTRL_RSTEN  0
`define CSI_CTRL_GINT   1
`define CSI_CMD_OP_HI   18
`define CSI_CMD_OP_LO   16
`define CSI_CMD_SEL     8
`define CSI_EV_OVF      0
`define CSI_EV_UNF      1
`define CSI_EV_RST      2
`define CSI_STACK_WIDTH 15
`define CSI_STACK_DEPTH 16
`define CSI_PTR_WIDTH   16
`define CSI_VECTOR      15'h0004
`define CSI_LIN_BASE    16'h2000
`define CSI_LIN_SIZE    16'h09B0
`define CSI_BANK_BYTES  16'h0050
`define CSI_BANK_GPR    12'h020
`define CSI_PROG_BIT    15
`endif

// ==== shared/csi_pkg.sv ====
// types shared by the stack, context and indirect pointer core
package csi_pkg;
	typedef enum logic [2:0] {
		CSI_OP_NONE   = 3'h0,
		CSI_OP_PUSH   = 3'h1,
		CSI_OP_POP    = 3'h2,
		CSI_OP_IRQ    = 3'h3,
		CSI_OP_RETI   = 3'h4,
		CSI_OP_IND    = 3'h5,
		CSI_OP_ADDPTR = 3'h6,
		CSI_OP_SPARE  = 3'h7
	} csi_op_type;
	typedef enum logic [1:0] {
		CSI_REG_FILE = 2'h0,
		CSI_REG_LIN  = 2'h1,
		CSI_REG_PROG = 2'h3
	} csi_region_type;
endpackage : csi_pkg

// ==== tb/tb_top.sv ====
// self-checking bench of the stack, context and pointer core
`timescale 1ns/100ps
`include "csi_defines.svh"
module tb_top
	import csi_pkg::*;
;
	typedef struct {logic wr; logic [9:0] idx; logic [31:0] d; logic [31:0] exp; logic err;} csi_row_type;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_s;
	logic        pready, pslverr, irq, stack_reset_pulse, prefetch_flush, err_s;
	int          errors, samples_checked, cycles, rst_pulses, flush_pulses, waits_s;
	csi_row_type rows [8] = '{
		'{1'b0, `CSI_IDX_CAUSE, 32'h0, 32'h0, 1'b0},
		'{1'b1, `CSI_IDX_PTR0, 32'h1234, 32'h0, 1'b0},
		'{1'b0, `CSI_IDX_PTR0, 32'h0, 32'h1234, 1'b0},
		'{1'b1, `CSI_IDX_PTR1, 32'hFFFF_ABCD, 32'h0, 1'b0},
		'{1'b0, `CSI_IDX_PTR1, 32'h0, 32'hABCD, 1'b0},
		'{1'b0, 10'h000, 32'h0, 32'h0, 1'b1},
		'{1'b1, 10'h3FF, 32'h5, 32'h0, 1'b1},
		'{1'b0, `CSI_IDX_CMD, 32'h0, 32'h0, 1'b0}};

	csi_core #(.DEPTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.stack_reset_pulse(stack_reset_pulse), .prefetch_flush(prefetch_flush));

	always #5 pclk = ~pclk;

	// pulses last one cycle, so they are counted rather than caught by a read
	always @(posedge pclk) begin
		cycles++;
		if (stack_reset_pulse === 1'b1) rst_pulses++;
		if (prefetch_flush === 1'b1) flush_pulses++;
		if (cycles == 20000) begin
			errors++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		if (errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// apb transfer; waits only end on pready, the cycle ceiling cuts a hang
	task automatic xfer(input logic wr_i, input logic [9:0] idx, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_i;
		paddr   <= {idx, 2'b00};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		waits_s = 0;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			waits_s++;
			@(posedge pclk);
		end
		rd_s = prdata;
		err_s = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic wr(input logic [9:0] idx, input logic [31:0] d);
		xfer(1'b1, idx, d);
	endtask : wr

	task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk(rd_s, exp);
	endtask : rc

	task automatic irq_is(input logic exp);
		repeat (2) @(posedge pclk);
		#1;
		chk({31'h0, irq}, {31'h0, exp});
	endtask : irq_is

	function automatic logic [31:0] cmd(input csi_op_type op, input logic [15:0] low);
		cmd = {13'h0000, op, low};
	endfunction : cmd

	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			xfer(rows[i].wr, rows[i].idx, rows[i].d);
			if (!rows[i].wr) chk(rd_s, rows[i].exp);
			chk({31'h0, err_s}, {31'h0, rows[i].err});
		end
		// fill to depth, then one push too many
		for (int i = 0; i < 16; i++) wr(`CSI_IDX_CMD, cmd(CSI_OP_PUSH, 16'h0100 + 16'(i)));
		rc(`CSI_IDX_TOS, 32'h0010_010F);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_PUSH, 16'h7777));
		rc(`CSI_IDX_CAUSE, 32'h80);
		rc(`CSI_IDX_TOS, 32'h0010_010F);
		for (int i = 15; i >= 0; i--) begin
			rc(`CSI_IDX_TOS, {11'h0, 5'(i + 1), 1'b0, 15'h0100 + 15'(i)});
			wr(`CSI_IDX_CMD, cmd(CSI_OP_POP, 16'h0));
		end
		rc(`CSI_IDX_TOS, 32'h0);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_POP, 16'h0));
		rc(`CSI_IDX_CAUSE, 32'hC0);
		rc(`CSI_IDX_ISTAT, 32'h3);
		// interrupt output: mask, unmask, clear
		irq_is(1'b0);
		wr(`CSI_IDX_IMASK, 32'h2);
		irq_is(1'b1);
		wr(`CSI_IDX_IMASK, 32'h1);
		wr(`CSI_IDX_ISTAT, 32'h1);
		irq_is(1'b0);
		rc(`CSI_IDX_ISTAT, 32'h2);
		wr(`CSI_IDX_ISTAT, 32'h2);
		wr(`CSI_IDX_CAUSE, 32'h40);
		rc(`CSI_IDX_CAUSE, 32'h40);
		wr(`CSI_IDX_CAUSE, 32'h0);
		// stack error with reset enabled; flags and pointers must survive it
		wr(`CSI_IDX_CTRL, 32'h3);
		wr(`CSI_IDX_PC, 32'h0055);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_POP, 16'h0));
		// pulse is launched at the access edge, counted one edge later
		@(posedge pclk);
		#1;
		chk(rst_pulses, 1);
		rc(`CSI_IDX_CAUSE, 32'h40);
		rc(`CSI_IDX_CTRL, 32'h1);
		rc(`CSI_IDX_PC, 32'h0);
		rc(`CSI_IDX_ISTAT, 32'h6);
		rc(`CSI_IDX_PTR0, 32'h1234);
		wr(`CSI_IDX_ISTAT, 32'h7);
		// entry refused while the enable is low
		wr(`CSI_IDX_CTRL, 32'h0);
		wr(`CSI_IDX_PC, 32'h0123);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_IRQ, 16'h0));
		rc(`CSI_IDX_PC, 32'h0123);
		chk(flush_pulses, 0);
		wr(`CSI_IDX_CTRL, 32'h2);
		wr(`CSI_IDX_CTX, 32'h0055);
		wr(`CSI_IDX_PTR0, 32'h2005);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_IRQ, 16'h0));
		@(posedge pclk);
		#1;
		chk(flush_pulses, 1);
		rc(`CSI_IDX_PC, 32'h0004);
		rc(`CSI_IDX_CTRL, 32'h0);
		rc(`CSI_IDX_TOS, 32'h0001_0123);
		rc(`CSI_IDX_SHADOW, 32'h0055);
		wr(`CSI_IDX_CTX, 32'h0099);
		wr(`CSI_IDX_PTR0, 32'h0001);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_RETI, 16'h0));
		rc(`CSI_IDX_PC, 32'h0123);
		rc(`CSI_IDX_CTX, 32'h0055);
		rc(`CSI_IDX_PTR0, 32'h2005);
		rc(`CSI_IDX_CTRL, 32'h2);
		// linear view: one bank past the base, offset five
		wr(`CSI_IDX_PTR1, 32'h2055);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_IND, 16'h0100));
		chk(32'(waits_s), 32'h0);
		rc(`CSI_IDX_IND, 32'h0001_00A5);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_ADDPTR, 16'h013F));
		rc(`CSI_IDX_PTR1, 32'h2054);
		wr(`CSI_IDX_PTR0, 32'h8010);
		wr(`CSI_IDX_CMD, cmd(CSI_OP_IND, 16'h0000));
		chk(32'(waits_s), 32'h1);
		xfer(1'b0, `CSI_IDX_IND, 32'h0);
		chk(rd_s & 32'h0103_0000, 32'h0103_0000);
		// second reset in mid-run clears the pointers
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rc(`CSI_IDX_PTR1, 32'h0);
		wrap_up();
	end
endmodule : tb_top
